// [core/tad_cfg.svh]
/*
 * register offsets, field positions, reset values and timing counts of the
 * transient acceleration event detector.
 * assumes: included by bare name from the top module of this block only.
 */
`ifndef TAD_CFG_SVH
`define TAD_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TAD_ADDR_CONFIG        8'h1D
`define TAD_ADDR_SOURCE        8'h1E
`define TAD_ADDR_THRESHOLD     8'h1F
`define TAD_ADDR_DEBOUNCE      8'h20

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define TAD_CFG_BYPASS_BIT     0
`define TAD_CFG_X_EN_BIT       1
`define TAD_CFG_Y_EN_BIT       2
`define TAD_CFG_Z_EN_BIT       3
`define TAD_CFG_LATCH_BIT      4
`define TAD_CFG_WRITE_MASK     8'h1F
`define TAD_SRC_X_POL_BIT      0
`define TAD_SRC_X_EV_BIT       1
`define TAD_SRC_Y_POL_BIT      2
`define TAD_SRC_Y_EV_BIT       3
`define TAD_SRC_Z_POL_BIT      4
`define TAD_SRC_Z_EV_BIT       5
`define TAD_SRC_ACTIVE_BIT     6
`define TAD_THR_MODE_BIT       7
`define TAD_REG_RESET          8'h00
`define TAD_THR_LOW_NOISE_MAX  7'h3F

// ****************************************************************
// timing
// ****************************************************************
`define TAD_CLK_PERIOD_NS      4
`define TAD_STEP_BASE_NS       1250000
`define TAD_STEP_BASE_CYCLES   (`TAD_STEP_BASE_NS / `TAD_CLK_PERIOD_NS)

`endif

// [core/tad_pkg.sv]
/*
 * types of the transient acceleration event detector.
 * assumes: tad_cfg.svh on the include path.
 */
`default_nettype none
package tad_pkg;
    typedef enum logic [1:0] {
        TAD_OS_NORMAL                   = 2'h0,
        TAD_OS_LOW_POWER_LOW_NOISE_MODE = 2'h1,
        TAD_OS_FINE_RESOLUTION_MODE     = 2'h2,
        TAD_OS_LOW_POWER_MODE           = 2'h3
    } tad_os_mode_t;
    typedef logic [7:0]        tad_byte_t;
    typedef logic signed [11:0] tad_sample_t;
endpackage
`default_nettype wire

// [core/tad_if.sv]
/*
 * carrier between the register side and the debounce counters.
 * assumes: both ends on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface tad_if;
    logic            step;
    logic [2:0]      cond;
    logic [7:0]      count;
    logic            clear_mode;
    logic [2:0]      hit;
    modport ctl (output step, output cond, output count, output clear_mode, input hit);
    modport dbn (input step, input cond, input count, input clear_mode, output hit);
endinterface
`default_nettype wire

// [core/tad_debounce.sv]
/*
 * three per-axis debounce counters stepped by the debounce time base.
 * assumes: step is a one-cycle pulse; cond and count steady around it.
 */
`timescale 1ns/100ps
`default_nettype none
module tad_debounce
    import tad_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    tad_if.dbn       bus
);
    logic [7:0] cnt_ff [3];

    function automatic logic [7:0] nxt_count(input logic [7:0] cnt, input logic [7:0] lim,
                                             input logic cond, input logic clr);
        if (cond) begin
            nxt_count = (cnt >= lim) ? lim : cnt + 8'h01;
        end else if (clr) begin
            nxt_count = 8'h00;
        end else begin
            nxt_count = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
        end
    endfunction

    // ****************************************************************
    // counters and hit levels
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                cnt_ff[i] <= 8'h00;
            end
            bus.hit <= 3'h0;
        end else if (bus.step) begin
            for (int i = 0; i < 3; i++) begin
                cnt_ff[i] <= nxt_count(cnt_ff[i], bus.count, bus.cond[i], bus.clear_mode);
                bus.hit[i] <= bus.cond[i] && (nxt_count(cnt_ff[i], bus.count, bus.cond[i], bus.clear_mode) >= bus.count);
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_step_false_x;
        bus.step && !bus.cond[0];
    endsequence

    property p_saturate;
        bus.step |=> cnt_ff[1] <= $past(bus.count);
    endproperty
    a_saturate: assert property (p_saturate) else $error("debounce count above limit");

    property p_clear_mode;
        s_step_false_x and bus.clear_mode |=> cnt_ff[0] == 8'h00;
    endproperty
    a_clear_mode: assert property (p_clear_mode) else $error("clear mode kept count");

    property p_decrement;
        s_step_false_x and !bus.clear_mode && cnt_ff[0] != 8'h00 |=> cnt_ff[0] == $past(cnt_ff[0]) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement) else $error("count not decremented by one");

    property p_hit_needs_count;
        bus.step && bus.cond[0] && {1'b0, cnt_ff[0]} + 9'h001 < {1'b0, bus.count} |=> !bus.hit[0];
    endproperty
    a_hit_needs_count: assert property (p_hit_needs_count) else $error("hit before count reached");
endmodule
`default_nettype wire

// [core/tad_top.sv]
/*
 * transient acceleration event detector: register file, sample capture,
 * threshold compare, debounce time base and event source register.
 * assumes: register strobes on clk; sample_clk is foreign and the axis
 * buses hold steady for a whole sample period around its rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tad_cfg.svh"
module tad_top
    import tad_pkg::*;
#(
    parameter int STEP_BASE_CYCLES = `TAD_STEP_BASE_CYCLES
)(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic [7:0]    reg_addr,
    input  wire logic          reg_wr_en,
    input  wire logic          reg_rd_en,
    input  wire logic [7:0]    reg_wdata,
    output var  logic [7:0]    reg_rdata_ff,
    input  wire logic          sample_clk,
    input  wire tad_sample_t   hpf_x,
    input  wire tad_sample_t   hpf_y,
    input  wire tad_sample_t   hpf_z,
    input  wire tad_sample_t   raw_x,
    input  wire tad_sample_t   raw_y,
    input  wire tad_sample_t   raw_z,
    input  wire logic [2:0]    output_sample_rate,
    input  wire tad_os_mode_t  oversample_mode,
    input  wire logic          low_noise,
    input  wire logic          irq_enable,
    output var  logic          transient_irq_ff
);
    tad_if dbus ();

    tad_byte_t   config_ff;
    tad_byte_t   source_ff;
    tad_byte_t   threshold_ff;
    tad_byte_t   count_ff;
    logic [2:0]  smp_sync_ff;
    logic        smp_level_ff;
    logic        smp_edge;
    tad_sample_t sel_ff [3];
    logic [31:0] step_cnt_ff;
    logic [31:0] step_last;
    logic        step_ff;
    logic [6:0]  thr_eff;
    logic [2:0]  cond;
    logic [2:0]  axis_en;
    logic [2:0]  hit_prev_ff;
    logic [2:0]  new_hit;
    logic        src_read;
    tad_byte_t   nxt_source;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] mag_units(input tad_sample_t s);
        logic [11:0] mag;
        mag = s[11] ? 12'(-s) : 12'(s);
        if (s == 12'sh800) begin
            mag = 12'hFFF;
        end
        mag_units = mag[11:4];
    endfunction

    function automatic logic [7:0] step_mult(input logic [2:0] rate, input tad_os_mode_t mode);
        logic [7:0] m;
        m = 8'h01 << rate;
        unique case (mode)
            TAD_OS_NORMAL: begin
                step_mult = (rate > 3'h4) ? 8'h10 : m;
            end
            TAD_OS_LOW_POWER_LOW_NOISE_MODE: begin
                step_mult = (rate > 3'h4) ? 8'h40 : m;
            end
            TAD_OS_FINE_RESOLUTION_MODE: begin
                step_mult = (rate == 3'h0) ? 8'h01 : 8'h02;
            end
            TAD_OS_LOW_POWER_MODE: begin
                step_mult = (rate == 3'h5) ? 8'h40 : ((rate > 3'h5) ? 8'h80 : m);
            end
        endcase
    endfunction

    // ****************************************************************
    // register writes
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            config_ff <= `TAD_REG_RESET;
        end else if (reg_wr_en && reg_addr == `TAD_ADDR_CONFIG) begin
            config_ff <= reg_wdata & `TAD_CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            threshold_ff <= `TAD_REG_RESET;
        end else if (reg_wr_en && reg_addr == `TAD_ADDR_THRESHOLD) begin
            threshold_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_ff <= `TAD_REG_RESET;
        end else if (reg_wr_en && reg_addr == `TAD_ADDR_DEBOUNCE) begin
            count_ff <= reg_wdata;
        end
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    assign src_read = reg_rd_en && reg_addr == `TAD_ADDR_SOURCE;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd_en) begin
            unique case (reg_addr)
                `TAD_ADDR_CONFIG:    reg_rdata_ff <= config_ff & `TAD_CFG_WRITE_MASK;
                `TAD_ADDR_SOURCE:    reg_rdata_ff <= {1'b0, source_ff[6:0]};
                `TAD_ADDR_THRESHOLD: reg_rdata_ff <= threshold_ff;
                `TAD_ADDR_DEBOUNCE:  reg_rdata_ff <= count_ff;
                default:             reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // sample clock synchroniser and capture
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            smp_sync_ff <= 3'h0;
        end else begin
            smp_sync_ff <= {smp_sync_ff[1:0], sample_clk};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            smp_level_ff <= 1'b0;
        end else if (smp_sync_ff[1] == smp_sync_ff[2]) begin
            smp_level_ff <= smp_sync_ff[2];
        end
    end

    assign smp_edge = (smp_sync_ff[1] == smp_sync_ff[2]) && smp_sync_ff[2] && !smp_level_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                sel_ff[i] <= 12'sh000;
            end
        end else if (smp_edge) begin
            sel_ff[0] <= config_ff[`TAD_CFG_BYPASS_BIT] ? raw_x : hpf_x;
            sel_ff[1] <= config_ff[`TAD_CFG_BYPASS_BIT] ? raw_y : hpf_y;
            sel_ff[2] <= config_ff[`TAD_CFG_BYPASS_BIT] ? raw_z : hpf_z;
        end
    end

    // ****************************************************************
    // threshold compare
    // ****************************************************************
    always_comb begin
        thr_eff = threshold_ff[6:0];
        if (low_noise && thr_eff > `TAD_THR_LOW_NOISE_MAX) begin
            thr_eff = `TAD_THR_LOW_NOISE_MAX;
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cond[i] = mag_units(sel_ff[i]) > {1'b0, thr_eff};
        end
    end

    // ****************************************************************
    // debounce time base
    // ****************************************************************
    assign step_last = 32'(STEP_BASE_CYCLES) * {24'h0, step_mult(output_sample_rate, oversample_mode)} - 32'h1;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            step_cnt_ff <= 32'h0;
            step_ff     <= 1'b0;
        end else if (step_cnt_ff >= step_last) begin
            step_cnt_ff <= 32'h0;
            step_ff     <= 1'b1;
        end else begin
            step_cnt_ff <= step_cnt_ff + 32'h1;
            step_ff     <= 1'b0;
        end
    end

    assign dbus.step       = step_ff;
    assign dbus.cond       = cond;
    assign dbus.count      = count_ff;
    assign dbus.clear_mode = threshold_ff[`TAD_THR_MODE_BIT];

    tad_debounce u_debounce (
        .clk    (clk),
        .resetn (resetn),
        .bus    (dbus)
    );

    // ****************************************************************
    // source register
    // ****************************************************************
    assign axis_en = {config_ff[`TAD_CFG_Z_EN_BIT], config_ff[`TAD_CFG_Y_EN_BIT], config_ff[`TAD_CFG_X_EN_BIT]};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hit_prev_ff <= 3'h0;
        end else begin
            hit_prev_ff <= dbus.hit;
        end
    end

    assign new_hit = dbus.hit & ~hit_prev_ff & axis_en;

    always_comb begin
        nxt_source = src_read ? 8'h00 : source_ff;
        if (config_ff[`TAD_CFG_LATCH_BIT]) begin
            for (int i = 0; i < 3; i++) begin
                if (new_hit[i]) begin
                    nxt_source[2 * i + 1] = 1'b1;
                    nxt_source[2 * i]     = sel_ff[i][11];
                end
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                nxt_source[2 * i + 1] = dbus.hit[i] & axis_en[i];
                nxt_source[2 * i]     = dbus.hit[i] & axis_en[i] & sel_ff[i][11];
            end
        end
        nxt_source[`TAD_SRC_ACTIVE_BIT] = nxt_source[5] | nxt_source[3] | nxt_source[1];
        nxt_source[7] = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            source_ff <= `TAD_REG_RESET;
        end else begin
            source_ff <= nxt_source;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            transient_irq_ff <= 1'b0;
        end else begin
            transient_irq_ff <= nxt_source[`TAD_SRC_ACTIVE_BIT] & irq_enable;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_src_read_quiet;
        src_read && new_hit == 3'h0 && (config_ff[`TAD_CFG_LATCH_BIT] || dbus.hit == 3'h0);
    endsequence

    property p_read_clears;
        s_src_read_quiet |=> source_ff == 8'h00 && !transient_irq_ff;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("source read did not clear");

    property p_latched_hold;
        config_ff[`TAD_CFG_LATCH_BIT] && source_ff[`TAD_SRC_X_EV_BIT] && !src_read |=> source_ff[`TAD_SRC_X_EV_BIT];
    endproperty
    a_latched_hold: assert property (p_latched_hold) else $error("latched event bit dropped");

    property p_frozen_pol;
        config_ff[`TAD_CFG_LATCH_BIT] && source_ff[6] && !src_read && !new_hit[1]
            |=> source_ff[`TAD_SRC_Y_POL_BIT] == $past(source_ff[`TAD_SRC_Y_POL_BIT]);
    endproperty
    a_frozen_pol: assert property (p_frozen_pol) else $error("frozen polarity moved");

    property p_active;
        source_ff[6] == (source_ff[5] | source_ff[3] | source_ff[1]);
    endproperty
    a_active: assert property (p_active) else $error("active flag mismatch");

    property p_disabled_axis;
        !axis_en[2] && !config_ff[`TAD_CFG_LATCH_BIT] |=> !source_ff[`TAD_SRC_Z_EV_BIT];
    endproperty
    a_disabled_axis: assert property (p_disabled_axis) else $error("disabled axis raised event");

    property p_bypass;
        smp_edge && config_ff[`TAD_CFG_BYPASS_BIT] |=> sel_ff[0] == $past(raw_x);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass sample not taken");

    property p_reserved;
        config_ff[7:5] == 3'h0 && !source_ff[7];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_irq_gate;
        !irq_enable |=> !transient_irq_ff;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");

    property p_low_noise;
        low_noise |-> thr_eff <= `TAD_THR_LOW_NOISE_MAX;
    endproperty
    a_low_noise: assert property (p_low_noise) else $error("low-noise limit exceeded");
endmodule
`default_nettype wire

// [dv/tad_sensor_model.sv]
/*
 * sample source standing in front of the detector: free-running sample
 * clock and the filtered and unfiltered three-axis buses.
 * assumes: the bench sets the wanted values at any time.
 */
`timescale 1ns/100ps
`default_nettype none
module tad_sensor_model
    import tad_pkg::*;
(
    input  wire tad_sample_t want_hpf [3],
    input  wire tad_sample_t want_raw [3],
    output var  logic        sample_clk,
    output var  tad_sample_t hpf [3],
    output var  tad_sample_t raw [3]
);
    // ****************************************************************
    // sample clock and buses
    // ****************************************************************
    initial begin
        sample_clk = 1'b0;
        hpf = '{default: '0};
        raw = '{default: '0};
    end
    // runs free, 125 ns period
    always #62.5 sample_clk = ~sample_clk;
    // buses move only after the falling edge, so they stand still around the rise
    always @(negedge sample_clk) begin
        hpf <= want_hpf;
        raw <= want_raw;
    end
endmodule
`default_nettype wire

// [dv/transient_accel_event_detector_test.sv]
/*
 * self-checking bench of the transient event detector.
 * assumes: core files and tad_sensor_model compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module transient_accel_event_detector_test
    import tad_pkg::*;
;
    localparam int           STEP = 64;
    localparam logic [2:0]   RATES [8] = '{3'h7, 3'h7, 3'h5, 3'h4, 3'h1, 3'h2, 3'h3, 3'h6};
    localparam tad_os_mode_t MODES [8] = '{TAD_OS_LOW_POWER_MODE, TAD_OS_FINE_RESOLUTION_MODE,
                                           TAD_OS_LOW_POWER_LOW_NOISE_MODE, TAD_OS_NORMAL, TAD_OS_NORMAL,
                                           TAD_OS_LOW_POWER_LOW_NOISE_MODE, TAD_OS_FINE_RESOLUTION_MODE,
                                           TAD_OS_NORMAL};
    localparam int           MULT [8]  = '{128, 2, 64, 16, 2, 4, 2, 16};
    logic         clk, resetn, wr_en, rd_en, low_noise, irq_en, irq, sclk;
    logic [7:0]   addr, wdata, rdata, got, cfg, thr, e;
    logic [2:0]   rate;
    logic [31:0]  seed, r;
    tad_os_mode_t osm;
    tad_sample_t  whpf [3], wraw [3], hpf [3], raw [3], s [3];
    int           failures, tests_run, cyc, per;

    tad_top #(.STEP_BASE_CYCLES(STEP)) u_dut (
        .clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_wdata(wdata), .reg_rdata_ff(rdata), .sample_clk(sclk), .hpf_x(hpf[0]), .hpf_y(hpf[1]),
        .hpf_z(hpf[2]), .raw_x(raw[0]), .raw_y(raw[1]), .raw_z(raw[2]), .output_sample_rate(rate),
        .oversample_mode(osm), .low_noise(low_noise), .irq_enable(irq_en), .transient_irq_ff(irq)
    );
    tad_sensor_model u_src (.want_hpf(whpf), .want_raw(wraw), .sample_clk(sclk), .hpf(hpf), .raw(raw));

    // ****************************************************************
    // helpers
    // ****************************************************************
    always #2 clk = ~clk;
    // clocks since reset release, to find the debounce step phase
    always @(posedge clk) cyc <= resetn ? cyc + 1 : 0;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic tad_sample_t smp(logic [11:0] v);
        return tad_sample_t'((v == 12'h800) ? 12'h801 : v);
    endfunction

    function automatic logic [7:0] exp_src(logic [7:0] c, logic [6:0] th, logic ln, tad_sample_t v [3]);
        logic [7:0]  q;
        logic [11:0] mag;
        logic [6:0]  t;
        q = 8'h00;
        t = (ln && th > 7'h3F) ? 7'h3F : th;
        for (int a = 0; a < 3; a++) begin
            mag = v[a][11] ? 12'(-v[a]) : 12'(v[a]);
            if (c[a + 1] && mag[11:4] > {1'b0, t}) begin
                q[2 * a + 1] = 1'b1;
                q[2 * a] = v[a][11];
            end
        end
        q[6] = |(q & 8'h2A);
        return q;
    endfunction

    task automatic chk(string what, logic [7:0] seen, logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    task automatic rd(logic [7:0] a);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        got = rdata;
    endtask

    // holds x for exactly k debounce steps, changed just after a step;
    // returns once the last of them has reached the source register
    task automatic steps(int k, int v);
        int guard;
        guard = 0;
        while (((cyc % per) < 4 || (cyc % per) > 8) && guard < 1000) begin
            @(negedge clk);
            guard++;
        end
        whpf[0] = 12'(v);
        repeat (k * per - (cyc % per) + 4) @(negedge clk);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        rate = 3'h0;
        osm = TAD_OS_NORMAL;
        low_noise = 1'b0;
        irq_en = 1'b1;
        seed = 32'h9ED6;
        per = STEP;
        failures = 0;
        tests_run = 0;
        whpf = '{default: '0};
        wraw = '{default: '0};
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        for (logic [7:0] a = 8'h1D; a != 8'h22; a++) begin
            rd(a);
            chk("reset value", got, 8'h00);
        end
        wr(8'h1D, 8'hFF);
        rd(8'h1D);
        chk("config bits", got, 8'h1F);
        wr(8'h1E, 8'hFF);
        rd(8'h1E);
        chk("source write", got, 8'h00);
        wr(8'h21, 8'hA5);
        rd(8'h21);
        chk("unmapped", got, 8'h00);
        // random live detections, every few a value right on the threshold
        for (int n = 0; n < 24; n++) begin
            r = xs();
            cfg = {4'h0, r[3:0]};
            thr = {r[4], r[11:5]};
            low_noise = r[12];
            irq_en = r[13];
            for (int a = 0; a < 3; a++) begin
                r = xs();
                whpf[a] = smp(r[11:0]);
                wraw[a] = smp(r[27:16]);
            end
            if (n % 4 == 0) begin
                whpf[0] = {1'b0, thr[6:0], 4'hF};
                wraw[0] = whpf[0];
            end
            wr(8'h1D, cfg);
            wr(8'h1F, thr);
            wr(8'h20, 8'h00);
            rd(8'h1F);
            chk("threshold", got, thr);
            repeat (2 * STEP + 8) @(negedge clk);
            for (int a = 0; a < 3; a++) s[a] = cfg[0] ? wraw[a] : whpf[a];
            e = exp_src(cfg, thr[6:0], low_noise, s);
            chk("irq", {7'h00, irq}, {7'h00, e[6] & irq_en});
            rd(8'h1E);
            chk("live source", got, e);
        end
        // latched: second axis joins, first axis polarity frozen, read clears all
        whpf = '{default: '0};
        wraw = '{default: '0};
        irq_en = 1'b1;
        low_noise = 1'b0;
        wr(8'h1F, 8'h05);
        wr(8'h1D, 8'h1E);
        repeat (2 * STEP + 8) @(negedge clk);
        rd(8'h1E);
        whpf[0] = -12'sd100;
        repeat (2 * STEP + 8) @(negedge clk);
        chk("irq set", {7'h00, irq}, 8'h01);
        whpf[0] = 12'sd100;
        whpf[1] = 12'sd200;
        repeat (2 * STEP + 8) @(negedge clk);
        whpf[0] = 12'sd0;
        repeat (2 * STEP + 8) @(negedge clk);
        rd(8'h1E);
        chk("latched source", got, 8'h4B);
        chk("irq cleared", {7'h00, irq}, 8'h00);
        rd(8'h1E);
        chk("source cleared", got, 8'h00);
        // debounce count, decrement or clear, saturation
        wr(8'h1D, 8'h02);
        wr(8'h20, 8'h03);
        for (int m = 0; m < 2; m++) begin
            wr(8'h1F, {m[0], 7'h05});
            steps(3, 0);
            steps(5, -100);
            steps(1, 0);
            steps(1, -100);
            rd(8'h1E);
            chk("debounce", got, m ? 8'h00 : 8'h43);
            steps(2, 0);
            steps(1, -100);
            rd(8'h1E);
            chk("saturate", got, 8'h00);
        end
        // slower time bases: second true step never comes before one whole period
        wr(8'h20, 8'h02);
        for (int t = 0; t < 8; t++) begin
            rate = RATES[t];
            osm = MODES[t];
            per = STEP * MULT[t];
            whpf[0] = 12'sd0;
            repeat (2 * per + 60) @(negedge clk);
            whpf[0] = -12'sd100;
            repeat (per + 10) @(negedge clk);
            rd(8'h1E);
            chk("early", got, 8'h00);
            repeat (per + 50) @(negedge clk);
            rd(8'h1E);
            chk("step", got, 8'h43);
        end
        test_done();
    end

    // longest pass is about 67000 clocks; cut a hang well past it
    initial begin
        #(85000 * 4);
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
